// ===== pkg/adcc_defines.vh
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADCC_OFF_CONTROL_ONE  4'h0
`define ADCC_OFF_RESULT       4'h4
`define ADCC_OFF_DMA_ADDR     4'h8
`define ADCC_OFF_INT_STATUS   4'hc
`define ADCC_OFF_INT_MASK     5'h10
`define ADCC_OFF_DMA_CONFIG   5'h14

// ----------------------------------------------------------------
// control one field positions
// ----------------------------------------------------------------
`define ADCC_BIT_CONVERTER_ON    15
`define ADCC_BIT_RSVD_14         14
`define ADCC_BIT_HALT_WHEN_IDLE  13
`define ADCC_BIT_DMA_BUILD_ORDER 12
`define ADCC_BIT_RSVD_11         11
`define ADCC_BIT_TWELVE_BIT      10
`define ADCC_BIT_FORMAT_HI       9
`define ADCC_BIT_FORMAT_LO       8
`define ADCC_BIT_TRIG_HI         7
`define ADCC_BIT_TRIG_LO         5
`define ADCC_BIT_TRIG_GROUP      4
`define ADCC_BIT_SIM_SAMPLING    3
`define ADCC_BIT_AUTO_SAMPLE     2
`define ADCC_BIT_SAMPLING        1
`define ADCC_BIT_DONE            0

// ----------------------------------------------------------------
// reset values and formats
// ----------------------------------------------------------------
`define ADCC_RST_CONTROL_ONE  16'h0000
`define ADCC_RST_INT_MASK     2'h0
`define ADCC_RST_DMA_CONFIG   3'h0
`define ADCC_RESULT_FORMAT_INTEGER     2'h0
`define ADCC_RESULT_FORMAT_SIGNED_INT  2'h1
`define ADCC_RESULT_FORMAT_FRACTION    2'h2
`define ADCC_RESULT_FORMAT_SIGNED_FRAC 2'h3

// ----------------------------------------------------------------
// interrupt status bits and bus answers
// ----------------------------------------------------------------
`define ADCC_INT_DONE    0
`define ADCC_INT_SAMPLE  1
`define ADCC_RESP_OKAY   2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

// ===== hw/adcc_format.v
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"

module adcc_format (
    // raw result and mode
    input  wire [11:0] raw_result,
    input  wire        twelve_bit,
    input  wire [1:0]  format_code,
    // formatted word
    output reg  [15:0] formatted
);

    always @* begin
        formatted = 16'h0000;
        if (twelve_bit) begin
            case (format_code)
                `ADCC_RESULT_FORMAT_SIGNED_FRAC: formatted = {~raw_result[11], raw_result[10:0], 4'h0};
                `ADCC_RESULT_FORMAT_FRACTION:    formatted = {raw_result, 4'h0};
                `ADCC_RESULT_FORMAT_SIGNED_INT:  formatted = {{5{~raw_result[11]}}, raw_result[10:0]};
                default:                formatted = {4'h0, raw_result};
            endcase
        end else begin
            case (format_code)
                `ADCC_RESULT_FORMAT_SIGNED_FRAC: formatted = {~raw_result[9], raw_result[8:0], 6'h00};
                `ADCC_RESULT_FORMAT_FRACTION:    formatted = {raw_result[9:0], 6'h00};
                `ADCC_RESULT_FORMAT_SIGNED_INT:  formatted = {{7{~raw_result[9]}}, raw_result[8:0]};
                default:                formatted = {6'h00, raw_result[9:0]};
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== hw/adcc_ctrl.v
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"

// Notes on behaviour
// - enable bit 15 runs the converter
// - bit 13 halts converter during idle
// - bit 12 set: dma gets buffer address
// - bit 12 clear: scatter/gather dma address
// - bit 10 selects 12-bit single channel
// - 10-bit left formats, optional msb invert
// - 10-bit right formats, zero or inverted fill
// - 12-bit left formats, optional msb invert
// - 12-bit right formats, zero or inverted fill
// - bits 14, 11 read zero; reset zero
// - done set by hardware, cleared by zero
// - auto-sample restarts sampling after conversion
module adcc_ctrl #(
    parameter BUF_PTR_W = 4,
    parameter ADDR_W    = 11
) (
    // clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite write address
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [7:0]        s_axi_awaddr,
    // axi4-lite write data
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    output reg  [1:0]        s_axi_bresp,
    // axi4-lite read
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    input  wire [7:0]        s_axi_araddr,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    // conversion engine
    input  wire              idle_mode,
    input  wire              conv_start,
    input  wire              conv_end,
    input  wire [11:0]       conv_result,
    input  wire [5:0]        conv_channel,
    output reg               converter_run_ff,
    output reg               sampling_active_ff,
    output reg               twelve_bit_select_ff,
    output reg  [4:0]        trigger_cfg_ff,
    // results and dma
    output reg  [15:0]       result_ff,
    output reg  [ADDR_W-1:0] dma_addr_ff,
    output reg               dma_req_ff,
    // interrupt
    output reg               irq_ff
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [15:0]          ctrl_ff;
    reg  [1:0]           int_status_ff;
    reg  [1:0]           int_mask_ff;
    reg  [2:0]           dma_size_ff;
    reg  [BUF_PTR_W-1:0] buf_ptr_ff;
    reg  [7:0]           aw_addr_ff;
    reg                  aw_held_ff;
    reg  [31:0]          w_data_ff;
    reg  [3:0]           w_strb_ff;
    reg                  w_held_ff;
    wire [15:0]          fmt_word;
    wire                 running;
    wire                 end_evt;
    wire                 start_evt;
    wire                 do_write;
    reg  [15:0]          nxt_ctrl;
    reg  [1:0]           nxt_status;
    reg  [ADDR_W-1:0]    nxt_dma_addr;
    reg  [31:0]          rd_word;
    reg                  rd_hit;
    wire                 lo_en;
    wire                 hi_en;
    wire [ADDR_W-1:0]    chan_base;
    wire [16:0]          chan_wide;

    assign running   = ctrl_ff[`ADCC_BIT_CONVERTER_ON]
                     & ~(ctrl_ff[`ADCC_BIT_HALT_WHEN_IDLE] & idle_mode);
    assign end_evt   = conv_end & running;
    assign start_evt = conv_start & running;
    assign do_write  = aw_held_ff & w_held_ff & ~s_axi_bvalid;
    // writes above the map must not alias onto it
    assign lo_en     = do_write & w_strb_ff[0] & (aw_addr_ff[7:5] == 3'h0);
    assign hi_en     = do_write & w_strb_ff[1] & (aw_addr_ff[7:5] == 3'h0);

    adcc_format u_format (
        .raw_result  (conv_result),
        .twelve_bit  (ctrl_ff[`ADCC_BIT_TWELVE_BIT]),
        .format_code (ctrl_ff[`ADCC_BIT_FORMAT_HI:`ADCC_BIT_FORMAT_LO]),
        .formatted   (fmt_word)
    );

    // ----------------------------------------------------------------
    // control register next value
    // ----------------------------------------------------------------
    always @* begin
        nxt_ctrl = ctrl_ff;
        if (aw_addr_ff[4:0] == {1'b0, `ADCC_OFF_CONTROL_ONE}) begin
            if (hi_en) begin
                nxt_ctrl[15:8] = w_data_ff[15:8];
            end
            if (lo_en) begin
                nxt_ctrl[7:1] = w_data_ff[7:1];
                if (!w_data_ff[`ADCC_BIT_DONE]) begin
                    nxt_ctrl[`ADCC_BIT_DONE] = 1'b0;
                end
            end
        end
        nxt_ctrl[`ADCC_BIT_RSVD_14] = 1'b0;
        nxt_ctrl[`ADCC_BIT_RSVD_11] = 1'b0;
        // done clears as a conversion begins
        if (start_evt) begin
            nxt_ctrl[`ADCC_BIT_DONE]     = 1'b0;
            nxt_ctrl[`ADCC_BIT_SAMPLING] = 1'b0;
        end
        if (end_evt) begin
            nxt_ctrl[`ADCC_BIT_DONE] = 1'b1;
            if (ctrl_ff[`ADCC_BIT_AUTO_SAMPLE]) begin
                nxt_ctrl[`ADCC_BIT_SAMPLING] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status next value
    // ----------------------------------------------------------------
    always @* begin
        nxt_status = int_status_ff;
        if (lo_en && aw_addr_ff[4:0] == {1'b0, `ADCC_OFF_INT_STATUS}) begin
            nxt_status = int_status_ff & ~w_data_ff[1:0];
        end
        if (end_evt) begin
            nxt_status[`ADCC_INT_DONE] = 1'b1;
        end
        if (end_evt && ctrl_ff[`ADCC_BIT_AUTO_SAMPLE]) begin
            nxt_status[`ADCC_INT_SAMPLE] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // dma address
    // ----------------------------------------------------------------
    // wide enough for a 6-bit index shifted by 7; ADDR_W up to 17
    assign chan_wide = {11'h000, conv_channel} << dma_size_ff;
    assign chan_base = chan_wide[ADDR_W-1:0];

    always @* begin
        if (ctrl_ff[`ADCC_BIT_DMA_BUILD_ORDER]) begin
            nxt_dma_addr = {{(ADDR_W-BUF_PTR_W){1'b0}}, buf_ptr_ff};
        end else begin
            nxt_dma_addr = chan_base;
        end
    end

    // ----------------------------------------------------------------
    // block registers
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff              <= `ADCC_RST_CONTROL_ONE;
            int_status_ff        <= 2'h0;
            int_mask_ff          <= `ADCC_RST_INT_MASK;
            dma_size_ff          <= `ADCC_RST_DMA_CONFIG;
            buf_ptr_ff           <= {BUF_PTR_W{1'b0}};
            converter_run_ff     <= 1'b0;
            sampling_active_ff   <= 1'b0;
            twelve_bit_select_ff <= 1'b0;
            trigger_cfg_ff       <= 5'h00;
            result_ff            <= 16'h0000;
            dma_addr_ff          <= {ADDR_W{1'b0}};
            dma_req_ff           <= 1'b0;
            irq_ff               <= 1'b0;
        end else begin
            ctrl_ff       <= nxt_ctrl;
            int_status_ff <= nxt_status;
            if (lo_en && aw_addr_ff[4:0] == `ADCC_OFF_INT_MASK) begin
                int_mask_ff <= w_data_ff[1:0];
            end
            if (lo_en && aw_addr_ff[4:0] == `ADCC_OFF_DMA_CONFIG) begin
                dma_size_ff <= w_data_ff[2:0];
            end
            converter_run_ff     <= running;
            sampling_active_ff   <= nxt_ctrl[`ADCC_BIT_SAMPLING];
            twelve_bit_select_ff <= nxt_ctrl[`ADCC_BIT_TWELVE_BIT];
            trigger_cfg_ff       <= nxt_ctrl[`ADCC_BIT_TRIG_HI:`ADCC_BIT_SIM_SAMPLING];
            dma_req_ff           <= end_evt;
            if (end_evt) begin
                result_ff   <= fmt_word;
                dma_addr_ff <= nxt_dma_addr;
                buf_ptr_ff  <= buf_ptr_ff + 1'b1;
            end
            if (!running) begin
                buf_ptr_ff <= {BUF_PTR_W{1'b0}};
            end
            irq_ff <= |(nxt_status & int_mask_ff);
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            aw_addr_ff    <= 8'h00;
            w_data_ff     <= 32'h0000_0000;
            w_strb_ff     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ADCC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_ff & ~(s_axi_awvalid & s_axi_awready)
                           & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held_ff & ~(s_axi_wvalid & s_axi_wready)
                           & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_ff[1:0] == 2'h0 && aw_addr_ff <= 8'h14)
                              ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // read decode
    // ----------------------------------------------------------------
    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            {4'h0, `ADCC_OFF_CONTROL_ONE}: begin
                rd_word[15:0] = ctrl_ff;
                // simultaneous sampling reads zero in 12-bit mode
                if (ctrl_ff[`ADCC_BIT_TWELVE_BIT]) begin
                    rd_word[`ADCC_BIT_SIM_SAMPLING] = 1'b0;
                end
            end
            {4'h0, `ADCC_OFF_RESULT}:     rd_word[15:0] = result_ff;
            {4'h0, `ADCC_OFF_DMA_ADDR}:   rd_word[ADDR_W-1:0] = dma_addr_ff;
            {4'h0, `ADCC_OFF_INT_STATUS}: rd_word[1:0] = int_status_ff;
            {3'h0, `ADCC_OFF_INT_MASK}:   rd_word[1:0] = int_mask_ff;
            {3'h0, `ADCC_OFF_DMA_CONFIG}: rd_word[2:0] = dma_size_ff;
            default:                      rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ADCC_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ===== test/adcc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    // engine and outputs
    input wire logic        conv_start,
    input wire logic        conv_end,
    input wire logic        converter_run_ff,
    input wire logic        sampling_active_ff,
    input wire logic [15:0] result_ff,
    input wire logic        dma_req_ff,
    input wire logic        irq_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // bus steps
    // ------------------------------------------------------------
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    // ------------------------------------------------------------
    // engine side
    // ------------------------------------------------------------
    a_rst_quiet: assert property (!$past(aresetn) |-> !irq_ff && !s_axi_bvalid && !converter_run_ff)
        else $error("outputs not quiet after reset");
    a_result_hold: assert property ($past(aresetn) && !$past(conv_end) |-> $stable(result_ff))
        else $error("result changed without conversion");
    a_dma_cause: assert property (dma_req_ff |-> $past(conv_end) && converter_run_ff)
        else $error("dma request without finished conversion");
    a_dma_pulse: assert property (dma_req_ff |=> !dma_req_ff)
        else $error("dma request longer than one cycle");
    a_sampling_active_clear: assert property (conv_start && !conv_end ##1 converter_run_ff
        |-> !sampling_active_ff)
        else $error("sampling not ended by conversion start");
endmodule
bind adcc_ctrl adcc_ctrl_chk i_chk (.*);
`default_nettype wire

// ===== test/tb_adc_control_register_one.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_register_one;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic        idle = 1'b0, cst = 1'b0, cend = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [11:0] cres = 12'h0;
    logic [5:0]  cch = 6'h0;
    logic [3:0]  ws = 4'hf;
    wire         awr, wrd, bv, arr, rv, run, sampling_active, irq, tws;
    wire  [4:0]  trg;
    wire  [10:0] dmaa;
    wire  [1:0]  br, rr;
    wire  [31:0] rdd;
    int          errors = 0, checked = 0, cyc = 0;
    logic [1:0]  qb[$];
    logic [33:0] qr[$];

    always #20 aclk = ~aclk;

    adcc_ctrl i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdd), .s_axi_rresp(rr),
        .idle_mode(idle), .conv_start(cst), .conv_end(cend),
        .conv_result(cres), .conv_channel(cch),
        .converter_run_ff(run), .sampling_active_ff(sampling_active), .twelve_bit_select_ff(tws),
        .trigger_cfg_ff(trg), .result_ff(), .dma_addr_ff(dmaa), .dma_req_ff(), .irq_ff(irq)
    );

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task chk_rd(input logic [33:0] g, input logic [33:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t read %h exp %h", $time, g, e);
        end
    endtask
    task chk_b(input logic [1:0] g, input logic [1:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t bresp %h exp %h", $time, g, e);
        end
    endtask
    task chk_lv(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t level %b exp %b", $time, g, e);
        end
    endtask
    task chk_out(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t output %h exp %h", $time, g, e);
        end
    endtask
    task final_report;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge aclk) begin
        if (rv && rre)
            chk_rd({rr, rdd}, qr.pop_front());
        if (bv && bre)
            chk_b(br, qb.pop_front());
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("BAD %0t timeout", $time);
            final_report;
        end
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        qb.push_back(r);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awr) begin aw = 1'b1; awv <= 1'b0; end
            if (!w && wrd) begin w = 1'b1; wv <= 1'b0; end
        end
        do @(posedge aclk); while (!bv);
        bre <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        @(posedge aclk);
        qr.push_back({r, e});
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        rre <= 1'b0;
    endtask
    task conv(input logic [11:0] r, input logic [5:0] c);
        @(posedge aclk); cst <= 1'b1;
        @(posedge aclk); cst <= 1'b0; cend <= 1'b1; cres <= r; cch <= c;
        @(posedge aclk); cend <= 1'b0;
        @(posedge aclk);
    endtask
    task settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask
    function logic [15:0] fmt(input logic [11:0] r, input logic t, input logic [1:0] f);
        if (t) case (f)
            2'h0: fmt = {4'h0, r};
            2'h1: fmt = {{5{~r[11]}}, r[10:0]};
            2'h2: fmt = {r, 4'h0};
            default: fmt = {~r[11], r[10:0], 4'h0};
        endcase
        else case (f)
            2'h0: fmt = {6'h0, r[9:0]};
            2'h1: fmt = {{7{~r[9]}}, r[8:0]};
            2'h2: fmt = {r[9:0], 6'h0};
            default: fmt = {~r[9], r[8:0], 6'h0};
        endcase
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [11:0] v;
        logic [15:0] c;
        logic [5:0]  ch;
        void'($urandom(32'h96b07bc3));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h00, 32'hffffffff);
        settle;
        chk_out({11'h000, trg}, 16'h001f);
        chk_lv(tws, 1'b1);
        rd(8'h00, 32'h0000b7f6);
        wr(8'h00, 32'h00000401);
        for (int t = 0; t < 2; t++) begin
            wr(8'h00, 32'h00000300);
            for (int f = 0; f < 4; f++) begin
                v = 12'($urandom);
                if (t == 0) v[11:10] = 2'b00;
                c = 16'((t << 10) | (f << 8));
                wr(8'h00, {16'h0, c});
                wr(8'h00, {16'h0, c | 16'h8000});
                conv(v, 6'h0);
                rd(8'h04, {16'h0, fmt(v, t[0], f[1:0])});
                rd(8'h00, {16'h0, c | 16'h8001});
            end
        end
        wr(8'h00, 32'h8700);
        rd(8'h00, 32'h8700);
        wr(8'h14, 32'h3);
        ch = 6'($urandom);
        conv(12'($urandom), ch);
        rd(8'h08, 32'(ch) << 3);
        wr(8'h00, 32'h00000700);
        wr(8'h00, 32'h00009700);
        conv(12'h000, 6'h05);
        conv(12'h000, 6'h05);
        rd(8'h08, 32'h1);
        settle;
        chk_out({5'h00, dmaa}, 16'h0001);
        wr(8'h0c, 32'h3);
        wr(8'h10, 32'h0);
        conv(12'h5a5, 6'h1);
        settle;
        chk_lv(irq, 1'b0);
        wr(8'h10, 32'h1);
        settle;
        chk_lv(irq, 1'b1);
        rd(8'h0c, 32'h1);
        wr(8'h0c, 32'h1);
        settle;
        chk_lv(irq, 1'b0);
        wr(8'h00, 32'h8704);
        conv(12'($urandom), 6'h2);
        settle;
        chk_lv(sampling_active, 1'b1);
        rd(8'h0c, 32'h3);
        wr(8'h00, 32'ha701);
        idle <= 1'b1;
        settle;
        chk_lv(run, 1'b0);
        wr(8'h00, 32'h8700);
        settle;
        chk_lv(run, 1'b1);
        wr(8'h00, 32'h00000400);
        settle;
        chk_lv(run, 1'b0);
        ws <= 4'h2;
        wr(8'h00, 32'h000084fe);
        ws <= 4'hf;
        rd(8'h00, 32'h00008400);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h40, 32'hffff, 2'h2);
        rd(8'h00, 32'h00008400);
        rd(8'h02, 32'h0, 2'h2);
        final_report;
    end
endmodule
`default_nettype wire
